// ---- design/wpi_target.sv ----
// Purpose: two-wire bus target that collects 16-bit command words and returns readbacks
// Assumes: scl and sda are open-drain pins sampled by sys_clk_i; no clock stretching
// Notes: command words leave through a 16-word buffer; the core answers nv_done_i
`timescale 1ns/1ps
`default_nettype none
module wpi_target
    import wpi_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic [1:0]        address_strap_pin_low_bits_i,
    input  wire logic [1:0]        address_strap_pin_high_bits_i,
    output logic      [WORD_W-1:0] cmd_word_o,
    output logic                   cmd_valid_o,
    input  wire logic              cmd_ready_i,
    input  wire logic [WORD_W-1:0] rd_data_i,
    input  wire logic              nv_done_i,
    output logic                   nv_busy_o
);
    logic [1:0]        rst_pipe_q;
    logic              rst_n;
    logic [1:0]        bus_s;
    logic [3:0]        strap_s;
    logic              scl_s;
    logic              sda_s;
    logic              scl_p_q;
    logic              sda_p_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic [1:0]        strap_cnt_q;
    logic              strap_taken_q;
    logic [6:0]        dev_addr_q;
    wpi_state_t        state_q;
    logic [3:0]        cnt_q;
    logic [7:0]        sh_q;
    logic [7:0]        hi_q;
    logic              have_hi_q;
    logic              rw_q;
    logic              match_q;
    logic              nack_q;
    logic              second_q;
    logic [7:0]        tx_sh_q;
    logic [7:0]        rd_lo_q;
    logic              push_q;
    logic [WORD_W-1:0] push_data_q;
    logic              busy_q;
    logic              armed_q;
    logic              byte_done;
    logic              addr_hit;
    logic              out_valid_q;
    logic [WORD_W-1:0] out_word_q;
    logic              sda_oe_q;

    wpi_fifo_if #(.W(WORD_W)) cmd_if ();

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pipe_q <= RST_PIPE_INIT;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    wpi_sync #(.W(2)) u_bus_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({!scl_i, !sda_i}),
        .q_o     (bus_s)
    );

    wpi_sync #(.W(4)) u_strap_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({address_strap_pin_high_bits_i, address_strap_pin_low_bits_i}),
        .q_o     (strap_s)
    );

    // pins pass inverted so the synchroniser's reset zero reads as an idle bus
    assign scl_s = !bus_s[1];
    assign sda_s = !bus_s[0];

    // 200 MHz oversamples even a 400 kHz bus by hundreds of samples per phase
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_p_q;
    assign scl_fall  = !scl_s && scl_p_q;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign byte_done = scl_fall && cnt_q == BITS_PER_BYTE;

    // straps taken once after reset, after the synchroniser has filled
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q   <= 2'h0;
            strap_taken_q <= 1'b0;
            dev_addr_q    <= 7'h00;
        end else if (!strap_taken_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_SETTLE) begin
                strap_taken_q <= 1'b1;
                dev_addr_q    <= {ADDR_FIXED, wpi_strap_bits(strap_s[3:2]),
                                  wpi_strap_bits(strap_s[1:0])};
            end
        end
    end

    // fixed 010 prefix never equals general call or a 10-bit prefix
    assign addr_hit = strap_taken_q && sh_q[7:1] == dev_addr_q
                      && !busy_q
                      && (!sh_q[0] || armed_q);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= WPI_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            hi_q      <= 8'h00;
            have_hi_q <= 1'b0;
            rw_q      <= 1'b0;
            match_q   <= 1'b0;
            nack_q    <= 1'b0;
            second_q  <= 1'b0;
            tx_sh_q   <= 8'h00;
            rd_lo_q   <= 8'h00;
        end else if (start_det) begin
            state_q   <= WPI_ADDR;
            cnt_q     <= 4'h0;
            have_hi_q <= 1'b0;
        end else if (stop_det) begin
            state_q   <= WPI_IDLE;
            have_hi_q <= 1'b0;
        end else begin
            case (state_q)
                WPI_ADDR: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        match_q <= addr_hit;
                        rw_q    <= sh_q[0];
                        state_q <= WPI_ADDR_ACK;
                    end
                end
                WPI_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (!match_q) begin
                            state_q <= WPI_IDLE;
                        end else if (rw_q) begin
                            state_q  <= WPI_TX;
                            tx_sh_q  <= rd_data_i[15:8];
                            rd_lo_q  <= rd_data_i[7:0];
                            second_q <= 1'b0;
                        end else begin
                            state_q <= WPI_RX;
                        end
                    end
                end
                WPI_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        state_q <= WPI_RX_ACK;
                        if (!have_hi_q) begin
                            hi_q      <= sh_q;
                            have_hi_q <= 1'b1;
                            match_q   <= 1'b1;
                        end else begin
                            have_hi_q <= 1'b0;
                            match_q   <= cmd_if.wr_ready;
                        end
                    end
                end
                WPI_RX_ACK: begin
                    if (scl_fall) begin
                        cnt_q   <= 4'h0;
                        state_q <= match_q ? WPI_RX : WPI_IDLE;
                    end
                end
                WPI_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        state_q <= WPI_TX_ACK;
                    end else if (scl_fall && cnt_q != 4'h0) begin
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                    end
                end
                WPI_TX_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (nack_q || second_q) begin
                            state_q <= WPI_IDLE;
                        end else begin
                            state_q  <= WPI_TX;
                            tx_sh_q  <= rd_lo_q;
                            second_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= WPI_IDLE;
                end
            endcase
        end
    end

    // a full buffer turns the low byte's acknowledge into a refusal
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            push_q      <= 1'b0;
            push_data_q <= 16'h0000;
        end else begin
            push_q <= state_q == WPI_RX && byte_done && have_hi_q
                      && cmd_if.wr_ready && !start_det && !stop_det;
            push_data_q <= {hi_q, sh_q};
        end
    end

    assign cmd_if.wr_valid = push_q;
    assign cmd_if.wr_data  = push_data_q;
    assign cmd_if.rd_ready = !out_valid_q || cmd_ready_i;

    wpi_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n),
        .f       (cmd_if.fifo)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            out_word_q  <= 16'h0000;
        end else if (cmd_if.rd_ready) begin
            out_valid_q <= cmd_if.rd_valid;
            out_word_q  <= cmd_if.rd_data;
        end
    end

    // programming busy: a new nv command wins over a done in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (push_q && wpi_is_nv_write(push_data_q)) begin
            busy_q <= 1'b1;
        end else if (nv_done_i) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (push_q && push_data_q[15:12] == CMD_READBACK) begin
            armed_q <= 1'b1;
        end else if (state_q == WPI_ADDR_ACK && scl_fall && match_q && rw_q) begin
            armed_q <= 1'b0;
        end
    end

    // drive changes one cycle after the state, still inside scl low
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_q <= 1'b0;
            sda_o    <= 1'b0;
        end else begin
            sda_oe_q <= (state_q == WPI_ADDR_ACK && match_q)
                        || (state_q == WPI_RX_ACK && match_q)
                        || (state_q == WPI_TX && !tx_sh_q[7]);
            sda_o    <= 1'b0;
        end
    end
    assign sda_oe_o    = sda_oe_q;
    assign cmd_word_o  = out_word_q;
    assign cmd_valid_o = out_valid_q;
    assign nv_busy_o   = busy_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);
    property p_addr_ack;
        state_q == WPI_ADDR && byte_done && addr_hit && !start_det && !stop_det
            |=> ##1 sda_oe_q;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
    property p_gen_call;
        state_q == WPI_ADDR && byte_done && sh_q[7:1] == 7'h00 |=> ##1 (!sda_oe_q)[*2];
    endproperty
    a_gen_call: assert property (p_gen_call) else $error("general call acked");
    // once taken the address must not follow later strap movement
    property p_addr_form;
        strap_taken_q |=> dev_addr_q[6:4] == ADDR_FIXED && $stable(dev_addr_q);
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("address prefix wrong");
    property p_busy_nack;
        state_q == WPI_ADDR && byte_done && busy_q |=> !match_q ##1 !sda_oe_q;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
    property p_nack_release;
        state_q == WPI_TX_ACK && scl_fall && nack_q && !start_det && !stop_det
            |=> state_q == WPI_IDLE ##1 !sda_oe_q;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("second byte after nack");
    property p_stable_high;
        $changed(sda_oe_q) && state_q != WPI_IDLE |-> !scl_p_q;
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("sda moved while scl high");
    property p_discard;
        start_det |=> state_q == WPI_ADDR && !have_hi_q && cnt_q == 4'h0;
    endproperty
    a_discard: assert property (p_discard) else $error("partial word kept");
    property p_push_word;
        state_q == WPI_RX && byte_done && have_hi_q && cmd_if.wr_ready
            && !start_det && !stop_det |=> push_q && push_data_q == {$past(hi_q), $past(sh_q)};
    endproperty
    a_push_word: assert property (p_push_word) else $error("word not pushed");
    property p_read_dir;
        state_q == WPI_ADDR_ACK && scl_fall && match_q && rw_q && !start_det && !stop_det
            |=> state_q == WPI_TX && !armed_q;
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("read did not transmit");
endmodule // wpi_target
`default_nettype wire

// ---- design/wpi_pkg.sv ----
// Purpose: shared constants, states and helpers of the wiper-interface bus target
// Assumes: 200 MHz system clock, two-wire bus at up to 400 kHz
// Notes: strap levels arrive already resolved into two-bit codes
package wpi_pkg;
    localparam int         WORD_W        = 16;
    localparam int         BYTE_W        = 8;
    localparam int         FIFO_DEPTH    = 16;
    localparam logic [2:0] ADDR_FIXED    = 3'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CMD_READBACK  = 4'h3;
    localparam logic [3:0] CMD_COPY_NV   = 4'h7;
    localparam logic [3:0] CMD_NV_WRITE  = 4'h8;
    localparam logic [1:0] STRAP_HIGH    = 2'h0;
    localparam logic [1:0] STRAP_OPEN    = 2'h2;
    localparam logic [1:0] STRAP_GROUND  = 2'h3;
    localparam logic [1:0] STRAP_SETTLE  = 2'h3;
    localparam logic [1:0] RST_PIPE_INIT = 2'h0;

    typedef enum logic [2:0] {
        WPI_IDLE     = 3'h0,
        WPI_ADDR     = 3'h1,
        WPI_ADDR_ACK = 3'h3,
        WPI_RX       = 3'h2,
        WPI_RX_ACK   = 3'h6,
        WPI_TX       = 3'h7,
        WPI_TX_ACK   = 3'h5
    } wpi_state_t;

    // an illegal strap code falls back to the tied-high address bits
    function automatic logic [1:0] wpi_strap_bits(input logic [1:0] lvl);
        case (lvl)
            STRAP_OPEN:   wpi_strap_bits = STRAP_OPEN;
            STRAP_GROUND: wpi_strap_bits = STRAP_GROUND;
            default:      wpi_strap_bits = STRAP_HIGH;
        endcase
    endfunction

    function automatic logic wpi_is_nv_write(input logic [WORD_W-1:0] w);
        wpi_is_nv_write = (w[15:12] == CMD_COPY_NV && w[0]) || (w[15:12] == CMD_NV_WRITE);
    endfunction
endpackage

// ---- design/wpi_fifo_if.sv ----
// Purpose: valid/ready carrier between the bus target and its command buffer
// Assumes: one clock for both sides
// Notes: a transfer happens when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface wpi_fifo_if #(parameter int W = 16);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ---- design/wpi_sync.sv ----
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to the clock
// Notes: only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module wpi_sync #(parameter int W = 2) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // wpi_sync
`default_nettype wire

// ---- design/wpi_fifo.sv ----
// Purpose: command word buffer with honest full and empty
// Assumes: DEPTH is a power of two
// Notes: read data is taken from the word at the read pointer
`timescale 1ns/1ps
`default_nettype none
module wpi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    wpi_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             do_wr;
    logic             do_rd;

    assign f.wr_ready = (wr_ptr_q - rd_ptr_q) != (AW+1)'(DEPTH);
    assign f.rd_valid = wr_ptr_q != rd_ptr_q;
    assign f.rd_data  = mem[rd_ptr_q[AW-1:0]];
    assign do_wr      = f.wr_valid && f.wr_ready;
    assign do_rd      = f.rd_valid && f.rd_ready;

    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr_q[AW-1:0]] <= f.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule // wpi_fifo
`default_nettype wire

// ---- bench/wpi_ctrl_model.sv ----
// Purpose: bus controller model for the wiper-interface target
// Assumes: 25 system clocks per bus bit (125 ns), sda pulled up
// Notes: scl rests high between frames; no clock stretching
`timescale 1ns/1ps
`default_nettype none
module wpi_ctrl_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic ph(input int n, input logic s, input logic p);
        repeat (n) @(negedge clk_i);
        scl_o      = s;
        sda_pull_o = p;
    endtask

    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        ph(6, 1'b0, !b);
        ph(6, 1'b1, !b);
        repeat (6) @(negedge clk_i);
        r = sda_i;
        ph(7, 1'b0, !b);
    endtask

    // also serves as repeated start when scl is low
    task automatic start();
        ph(6, scl_o, 1'b0);
        ph(6, 1'b1, 1'b0);
        ph(6, 1'b1, 1'b1);
        ph(7, 1'b0, 1'b1);
    endtask

    task automatic stop();
        ph(6, 1'b0, 1'b1);
        ph(6, 1'b1, 1'b1);
        ph(6, 1'b1, 1'b0);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // ack low leaves sda high on the ninth clock
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(!ack, r);
    endtask
endmodule // wpi_ctrl_model
`default_nettype wire

// ---- bench/tb_wpi_target.sv ----
// Purpose: self-checking bench of the wiper-interface bus target
// Assumes: bus clock 125 ns, commands consumed by a random-ready sink
// Notes: expected words kept in a queue; straps swept across resets
`timescale 1ns/1ps
`default_nettype none
module tb_wpi_target
    import wpi_pkg::*;
;
    logic              clk          = 1'b0;
    logic              arst_n       = 1'b0;
    logic              nv_done      = 1'b0;
    logic              stall        = 1'b0;
    logic              cmd_ready    = 1'b0;
    logic              scl;
    logic              pull;
    logic              sda_oe;
    logic              cmd_valid;
    logic              nv_busy;
    logic [1:0]        lo           = 2'h0;
    logic [1:0]        hi           = 2'h0;
    logic [1:0]        codes [3]    = '{STRAP_HIGH, STRAP_OPEN, STRAP_GROUND};
    logic [15:0]       nv_cmds [2]  = '{{CMD_NV_WRITE, 12'h000}, {CMD_COPY_NV, 12'h001}};
    logic [6:0]        own;
    logic [15:0]       cmd_word;
    logic [15:0]       rd_data      = 16'h0;
    logic [15:0]       exp_q [$];
    int                errors       = 0;
    int                samples_checked = 0;
    int                seed         = 32'h8e6297e4;
    logic              sda_out;
    wire               sda          = !((sda_oe && !sda_out) | pull);

    always #2.5 clk = ~clk;

    wpi_ctrl_model u_wpi_ctrl_model (
        .clk_i      (clk),
        .sda_i      (sda),
        .scl_o      (scl),
        .sda_pull_o (pull)
    );

    wpi_target u_wpi_target (
        .sys_clk_i                     (clk),
        .arst_n_i                      (arst_n),
        .scl_i                         (scl),
        .sda_i                         (sda),
        .sda_o                         (sda_out),
        .sda_oe_o                      (sda_oe),
        .address_strap_pin_low_bits_i  (lo),
        .address_strap_pin_high_bits_i (hi),
        .cmd_word_o                    (cmd_word),
        .cmd_valid_o                   (cmd_valid),
        .cmd_ready_i                   (cmd_ready),
        .rd_data_i                     (rd_data),
        .nv_done_i                     (nv_done),
        .nv_busy_o                     (nv_busy)
    );

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // a word with nobody expecting it compares against unknown and fails
    always @(posedge clk) begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
            if (exp_q.size() == 0) exp_q.push_back('x);
            check("cmd_word", cmd_word, exp_q.pop_front());
        end
    end

    always @(negedge clk) cmd_ready <= stall ? 1'b0 : 1'($random(seed));

    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        u_wpi_ctrl_model.wr_byte(d, a);
        check("ack", {15'h0, a}, {15'h0, e});
    endtask

    task automatic addr(input logic [7:0] b, input logic e);
        u_wpi_ctrl_model.start();
        wb(b, e);
    endtask

    task automatic stp();
        u_wpi_ctrl_model.stop();
    endtask

    // push before the low byte: the word may leave during its ack
    task automatic send(input logic [15:0] w, input logic e);
        wb(w[15:8], 1'b1);
        if (e) exp_q.push_back(w);
        wb(w[7:0], e);
    endtask

    function automatic logic [15:0] rnd_word();
        logic [15:0] w;
        w = 16'($random(seed));
        w[15:12] = w[15:12] % 4'h7;
        return w;
    endfunction

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (30) @(negedge clk);
    endtask

    task automatic drain();
        for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(negedge clk);
    endtask

    task automatic rdback(input logic ack1);
        logic [7:0] b1;
        logic [7:0] b2;
        addr({own, 1'b0}, 1'b1);
        send({CMD_READBACK, 12'h003}, 1'b1);
        stp();
        rd_data = 16'($random(seed));
        addr({own, 1'b1}, 1'b1);
        u_wpi_ctrl_model.rd_byte(ack1, b1);
        u_wpi_ctrl_model.rd_byte(1'b0, b2);
        stp();
        check("rd_word", {b1, b2}, ack1 ? rd_data : {rd_data[15:8], 8'hFF});
        check("sda_o", {15'h0, sda_out}, 16'h0);
    endtask

    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end

    initial begin
        for (int i = 0; i < 9; i++) begin
            lo = codes[i % 3];
            hi = codes[i / 3];
            do_reset();
            own = {3'h2, hi, lo};
            addr({own, 1'b0}, 1'b1);
            stp();
            addr({own ^ 7'h01, 1'b0}, 1'b0);
            stp();
        end
        addr(8'h00, 1'b0);
        stp();
        addr(8'hF0, 1'b0);
        stp();
        addr({own, 1'b0}, 1'b1);
        for (int i = 0; i < 3; i++) send(rnd_word(), 1'b1);
        wb(8'hA5, 1'b1);
        stp();
        addr({own, 1'b0}, 1'b1);
        wb(8'h12, 1'b1);
        addr({own, 1'b0}, 1'b1);
        send(16'h2345, 1'b1);
        stp();
        rdback(1'b1);
        addr({own, 1'b1}, 1'b0);
        stp();
        rdback(1'b0);
        for (int k = 0; k < 2; k++) begin
            addr({own, 1'b0}, 1'b1);
            send(nv_cmds[k], 1'b1);
            stp();
            check("busy", {15'h0, nv_busy}, 16'h1);
            addr({own, 1'b0}, 1'b0);
            stp();
            nv_done = 1'b1;
            @(negedge clk);
            nv_done = 1'b0;
            repeat (2) @(negedge clk);
            check("busy", {15'h0, nv_busy}, 16'h0);
            addr({own, 1'b0}, 1'b1);
            stp();
        end
        drain();
        stall = 1'b1;
        addr({own, 1'b0}, 1'b1);
        for (int i = 0; i < 18; i++) send(rnd_word(), i < 17);
        stp();
        stall = 1'b0;
        drain();
        check("left", 16'(exp_q.size()), 16'h0);
        tally_and_finish();
    end
endmodule // tb_wpi_target
`default_nettype wire
